// ===== core/acs_cfg.svh
// offsets, field positions, reset values and unlock key of the algorithm command/status registers
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

`define ACS_ADDR_W          12
`define ACS_OFF_CMD_WORD    12'h0e6
`define ACS_OFF_STATUS      12'h0ec

`define ACS_CMD_RESET       32'h0000_0000
`define ACS_STATUS_RESET    32'h0000_0000

`define ACS_BIT_STORE       31
`define ACS_BIT_LOAD        30
`define ACS_BIT_FAULT_CLR   29
`define ACS_BIT_RETRY_CLR   28
`define ACS_KEY_MSB         27
`define ACS_KEY_LSB         20
`define ACS_BIT_ALIVE       0

`define ACS_CUR_MSB         31
`define ACS_CUR_LSB         16
`define ACS_PWR_MSB         15
`define ACS_PWR_LSB         0

// arbitrary unlock value, replace with the product value
`define ACS_UNLOCK_KEY      8'h5a

// internal controller must answer a non-volatile request within this many cycles
`define ACS_NVM_TIMEOUT     16'h0400

`endif

// ===== core/acs_pkg.sv
// types shared by the algorithm command/status register modules
package acs_pkg;

   typedef logic [31:0] acs_word_t;
   typedef logic [15:0] acs_half_t;
   typedef logic [11:0] acs_addr_t;
   typedef logic [7:0]  acs_key_t;

   typedef enum logic [2:0] {
      ACS_NVM_IDLE  = 3'b001,
      ACS_NVM_STORE = 3'b010,
      ACS_NVM_LOAD  = 3'b100
   } acs_nvm_state_t;

   typedef struct packed {
      logic store;
      logic load;
      logic fault_clr;
      logic retry_clr;
      logic alive;
      logic key_bad;
   } acs_cmd_t;

endpackage

// ===== core/acs_cmd_if.sv
// carrier between the command decoder and the register bank
`timescale 1ns/100ps
interface acs_cmd_if;
   import acs_pkg::*;
   acs_word_t wdata;
   logic      wr_hit;
   acs_cmd_t  cmd;

   modport bank (output wdata, output wr_hit, input cmd);
   modport dec  (input wdata, input wr_hit, output cmd);
endinterface

// ===== core/acs_cmd_decode.sv
// splits a command-word write into one-cycle action requests
`timescale 1ns/100ps
`include "acs_cfg.svh"
module acs_cmd_decode (
   acs_cmd_if.dec cif
);
   import acs_pkg::*;

   function automatic logic key_ok(input acs_word_t w);
      key_ok = (w[`ACS_KEY_MSB:`ACS_KEY_LSB] == `ACS_UNLOCK_KEY);
   endfunction

   logic store_bit;

   always_comb begin
      store_bit         = cif.wr_hit & cif.wdata[`ACS_BIT_STORE];
      // store only with the right key; a bad key turns the request into a reject report
      cif.cmd.store     = store_bit & key_ok(cif.wdata);
      cif.cmd.key_bad   = store_bit & ~key_ok(cif.wdata);
      cif.cmd.load      = cif.wr_hit & cif.wdata[`ACS_BIT_LOAD];
      cif.cmd.fault_clr = cif.wr_hit & cif.wdata[`ACS_BIT_FAULT_CLR];
      cif.cmd.retry_clr = cif.wr_hit & cif.wdata[`ACS_BIT_RETRY_CLR];
      cif.cmd.alive     = cif.wr_hit & cif.wdata[`ACS_BIT_ALIVE];
   end

endmodule // acs_cmd_decode

// ===== core/acs_regs.sv
// algorithm command word and bus current/power status register bank
`timescale 1ns/100ps
`include "acs_cfg.svh"

// Functional notes
// - the upper half of the status word carries bus current in units of 1/256 A.
// - the lower half of the status word carries input power in units of 1/64 W.
// - writing one to the store bit copies the shadow configuration into non-volatile memory.
// - writing one to the load bit copies the stored defaults from non-volatile memory into the shadow registers.
// - writing one to the fault clear bit clears all driver and controller faults.
// - writing one to the retry clear bit resets the lock-fault retry counters.
// - the store only happens when the 8-bit key field holds the valid unlock key.
// - the internal controller returns the host alive bit to zero after the host sets it.
// - the command word sits at offset e6h, resets to zero, and every field is writable.
module acs_regs (
   input  wire logic             SYS_CLK,
   input  wire logic             SRST,
   input  wire logic             CE,
   input  wire logic             REG_WR,
   input  wire logic             REG_RD,
   input  wire acs_pkg::acs_addr_t REG_ADDR,
   input  wire acs_pkg::acs_word_t REG_WDATA,
   output      acs_pkg::acs_word_t REG_RDATA,
   output      logic             REG_RVALID,
   input  wire acs_pkg::acs_half_t BUS_CURRENT_IN,
   input  wire acs_pkg::acs_half_t INPUT_POWER_IN,
   input  wire logic             NVM_DONE,
   input  wire logic             HOST_ALIVE_ACK,
   output      logic             NVM_STORE_REQ,
   output      logic             NVM_LOAD_REQ,
   output      logic             NVM_BUSY,
   output      logic             NVM_TIMEOUT,
   output      logic             FAULT_CLEAR,
   output      logic             RETRY_CLEAR,
   output      logic             HOST_ALIVE,
   output      logic             KEY_REJECT,
   output      logic             CMD_REFUSED
);
   import acs_pkg::*;

   acs_cmd_if cif ();

   acs_cmd_decode acs_cmd_decode_inst (
      .cif (cif.dec)
   );

   acs_word_t      status_reg;
   acs_word_t      rdata_reg;
   logic           rvalid_reg;
   acs_nvm_state_t nvm_state_reg;
   acs_nvm_state_t nvm_state_next;
   logic [15:0]    wait_cnt_reg;
   logic           store_req_reg;
   logic           load_req_reg;
   logic           timeout_reg;
   logic           fault_clr_reg;
   logic           retry_clr_reg;
   logic           alive_reg;
   logic           key_rej_reg;
   logic           refused_reg;
   logic           nvm_start;
   logic           nvm_refuse;
   logic           busy_reg;
   logic [15:0]    busy_run_reg;

   // write-only word: only the exact offset is decoded, anything else is dropped
   assign cif.wr_hit = CE & REG_WR & (REG_ADDR == `ACS_OFF_CMD_WORD);
   assign cif.wdata  = REG_WDATA;

   // status snapshot, refreshed every enabled cycle so a read sees a coherent pair
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         status_reg <= `ACS_STATUS_RESET;
      end else if (CE) begin
         status_reg <= {BUS_CURRENT_IN, INPUT_POWER_IN};
      end
   end

   // read port: one-cycle answer; command word is write-only and unmapped offsets read zero
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         rdata_reg  <= 32'h0000_0000;
         rvalid_reg <= 1'b0;
      end else if (CE) begin
         rvalid_reg <= REG_RD;
         if (REG_RD && REG_ADDR == `ACS_OFF_STATUS) begin
            rdata_reg <= status_reg;
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end

   // non-volatile sequencer: one request at a time, store beats load when both are written
   assign nvm_start  = (cif.cmd.store | cif.cmd.load) & (nvm_state_reg == ACS_NVM_IDLE);
   assign nvm_refuse = (cif.cmd.store | cif.cmd.load) & (nvm_state_reg != ACS_NVM_IDLE);

   always_comb begin
      nvm_state_next = nvm_state_reg;
      unique case (nvm_state_reg)
         ACS_NVM_IDLE: begin
            if (cif.cmd.store) begin
               nvm_state_next = ACS_NVM_STORE;
            end else if (cif.cmd.load) begin
               nvm_state_next = ACS_NVM_LOAD;
            end
         end
         ACS_NVM_STORE,
         ACS_NVM_LOAD: begin
            // a controller that never answers must not lock the port out forever
            if (NVM_DONE || wait_cnt_reg == `ACS_NVM_TIMEOUT) begin
               nvm_state_next = ACS_NVM_IDLE;
            end
         end
         default: begin
            nvm_state_next = ACS_NVM_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         nvm_state_reg <= ACS_NVM_IDLE;
         busy_reg      <= 1'b0;
      end else if (CE) begin
         nvm_state_reg <= nvm_state_next;
         // busy mirrors the state register so the output comes from a flip-flop
         busy_reg      <= (nvm_state_next != ACS_NVM_IDLE);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         wait_cnt_reg <= 16'h0000;
      end else if (CE) begin
         if (nvm_state_reg == ACS_NVM_IDLE) begin
            wait_cnt_reg <= 16'h0000;
         end else begin
            wait_cnt_reg <= wait_cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         timeout_reg <= 1'b0;
      end else if (CE) begin
         timeout_reg <= (nvm_state_reg != ACS_NVM_IDLE) && !NVM_DONE && (wait_cnt_reg == `ACS_NVM_TIMEOUT);
      end else begin
         timeout_reg <= 1'b0;
      end
   end

   // request pulses last one cycle, so every accepted write of one gives exactly one action
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         store_req_reg <= 1'b0;
         load_req_reg  <= 1'b0;
      end else if (CE) begin
         store_req_reg <= nvm_start & cif.cmd.store;
         load_req_reg  <= nvm_start & ~cif.cmd.store & cif.cmd.load;
      end else begin
         store_req_reg <= 1'b0;
         load_req_reg  <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         fault_clr_reg <= 1'b0;
         retry_clr_reg <= 1'b0;
      end else if (CE) begin
         fault_clr_reg <= cif.cmd.fault_clr;
         retry_clr_reg <= cif.cmd.retry_clr;
      end else begin
         fault_clr_reg <= 1'b0;
         retry_clr_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         key_rej_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else if (CE) begin
         key_rej_reg <= cif.cmd.key_bad;
         refused_reg <= nvm_refuse;
      end else begin
         key_rej_reg <= 1'b0;
         refused_reg <= 1'b0;
      end
   end

   // host alive flag: set by the host, cleared by the controller's acknowledge; a set wins
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         alive_reg <= 1'b0;
      end else if (CE) begin
         if (cif.cmd.alive) begin
            alive_reg <= 1'b1;
         end else if (HOST_ALIVE_ACK) begin
            alive_reg <= 1'b0;
         end
      end
   end

   assign REG_RDATA     = rdata_reg;
   assign REG_RVALID    = rvalid_reg;
   assign NVM_STORE_REQ = store_req_reg;
   assign NVM_LOAD_REQ  = load_req_reg;
   assign NVM_BUSY      = busy_reg;
   assign NVM_TIMEOUT   = timeout_reg;
   assign FAULT_CLEAR   = fault_clr_reg;
   assign RETRY_CLEAR   = retry_clr_reg;
   assign HOST_ALIVE    = alive_reg;
   assign KEY_REJECT    = key_rej_reg;
   assign CMD_REFUSED   = refused_reg;

   status_read_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (CE && REG_RD && REG_ADDR == `ACS_OFF_STATUS && $past(CE))
      |=> REG_RVALID && REG_RDATA[31:16] == $past(BUS_CURRENT_IN, 2))
      else $error("status read lost the bus current half");

   power_half_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (CE && REG_RD && REG_ADDR == `ACS_OFF_STATUS && $past(CE))
      |=> REG_RDATA[15:0] == $past(INPUT_POWER_IN, 2))
      else $error("status read lost the power half");

   store_key_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cif.wr_hit && REG_WDATA[`ACS_BIT_STORE] && REG_WDATA[`ACS_KEY_MSB:`ACS_KEY_LSB] == `ACS_UNLOCK_KEY
       && !NVM_BUSY) |=> NVM_STORE_REQ ##1 NVM_BUSY)
      else $error("keyed store not issued");

   load_issue_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cif.wr_hit && REG_WDATA[`ACS_BIT_LOAD] && !REG_WDATA[`ACS_BIT_STORE] && !NVM_BUSY)
      |=> NVM_LOAD_REQ && !NVM_STORE_REQ)
      else $error("load not issued");

   fault_clr_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      FAULT_CLEAR |-> $past(cif.wr_hit) && $past(REG_WDATA[`ACS_BIT_FAULT_CLR]))
      else $error("fault clear without a write");

   retry_clr_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cif.wr_hit && REG_WDATA[`ACS_BIT_RETRY_CLR]) |=> RETRY_CLEAR)
      else $error("retry clear missed");

   bad_key_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cif.wr_hit && REG_WDATA[`ACS_BIT_STORE] && REG_WDATA[`ACS_KEY_MSB:`ACS_KEY_LSB] != `ACS_UNLOCK_KEY)
      |=> KEY_REJECT && !NVM_STORE_REQ)
      else $error("store taken with a bad key");

   alive_hold_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (HOST_ALIVE && CE && HOST_ALIVE_ACK && !cif.cmd.alive) |=> !HOST_ALIVE)
      else $error("alive flag not returned to zero");

   alive_set_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (cif.wr_hit && REG_WDATA[`ACS_BIT_ALIVE]) |=> HOST_ALIVE)
      else $error("alive flag not set");

   other_off_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (CE && REG_WR && REG_ADDR != `ACS_OFF_CMD_WORD) |=> !FAULT_CLEAR && !RETRY_CLEAR && !NVM_LOAD_REQ)
      else $error("write to another offset had an effect");

   pulse_one_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      (!cif.cmd.fault_clr && !cif.cmd.retry_clr) |=> !FAULT_CLEAR && !RETRY_CLEAR)
      else $error("command pulse held");

   reset_zero_a: assert property (@(posedge SYS_CLK)
      (!SRST && $past(SRST)) |-> !HOST_ALIVE && !NVM_BUSY && !FAULT_CLEAR && !NVM_STORE_REQ)
      else $error("command state not zero after reset");

   // helper for the bound below: a delay range this long is too costly to unroll
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         busy_run_reg <= 16'h0000;
      end else if (CE) begin
         if (!NVM_BUSY) begin
            busy_run_reg <= 16'h0000;
         end else if (busy_run_reg != 16'hffff) begin
            busy_run_reg <= busy_run_reg + 16'h0001;
         end
      end
   end

   nvm_bound_a: assert property (@(posedge SYS_CLK) disable iff (SRST)
      busy_run_reg <= `ACS_NVM_TIMEOUT + 16'h0001)
      else $error("sequencer stuck busy");

endmodule // acs_regs

// ===== dv/acs_ctl_model.sv
// internal controller stand-in: answers non-volatile requests and retires the host alive flag
`timescale 1ns/100ps
module acs_ctl_model (
   input  wire logic        SYS_CLK,
   input  wire logic        SRST,
   input  wire logic        STORE_REQ,
   input  wire logic        LOAD_REQ,
   input  wire logic        HOST_ALIVE,
   input  wire logic [11:0] DELAY,
   input  wire logic        MUTE,
   output      logic        NVM_DONE,
   output      logic        HOST_ALIVE_ACK
);
   logic [11:0] wait_reg;
   logic        pend_reg;
   logic [1:0]  seen_reg;

   // mute models a stuck memory so that the requester's timeout can be reached
   always_ff @(posedge SYS_CLK) begin
      NVM_DONE <= 1'b0;
      if (SRST) begin
         pend_reg <= 1'b0;
         wait_reg <= '0;
      end else if (STORE_REQ || LOAD_REQ) begin
         pend_reg <= ~MUTE;
         wait_reg <= DELAY;
      end else if (pend_reg) begin
         if (wait_reg == 12'h000) begin
            NVM_DONE <= 1'b1;
            pend_reg <= 1'b0;
         end else begin
            wait_reg <= wait_reg - 12'h001;
         end
      end
   end

   // the flag is retired a few cycles after it is seen, never at once
   always_ff @(posedge SYS_CLK) begin
      HOST_ALIVE_ACK <= 1'b0;
      if (SRST || !HOST_ALIVE) begin
         seen_reg <= 2'b00;
      end else if (seen_reg == 2'b11) begin
         HOST_ALIVE_ACK <= 1'b1;
         seen_reg <= 2'b00;
      end else begin
         seen_reg <= seen_reg + 2'b01;
      end
   end
endmodule // acs_ctl_model

// ===== dv/tb_acs_regs.sv
// self-checking bench for the algorithm command word and bus current/power status registers
`timescale 1ns/100ps
`include "acs_cfg.svh"
module tb_acs_regs;
   import acs_pkg::*;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic        ce = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   acs_addr_t   reg_addr = '0;
   acs_word_t   reg_wdata = '0;
   acs_half_t   cur_in = '0;
   acs_half_t   pwr_in = '0;
   logic [11:0] delay = 12'h004;
   logic        mute = 1'b0;
   acs_word_t   reg_rdata;
   logic        reg_rvalid, nvm_done, alive_ack, store_req, load_req, nvm_busy;
   logic        nvm_timeout, fault_clr, retry_clr, host_alive, key_reject, cmd_refused;
   int          n_fail = 0;
   int          checks_done = 0;
   int          cnt [7];
   // hex digit order of expected counts: store, load, fault, retry, timeout, key reject, refused
   wire logic [6:0] pulses = {store_req, load_req, fault_clr, retry_clr, nvm_timeout, key_reject, cmd_refused};

   acs_regs acs_regs_inst (.SYS_CLK(sys_clk), .SRST(srst), .CE(ce), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
      .BUS_CURRENT_IN(cur_in), .INPUT_POWER_IN(pwr_in), .NVM_DONE(nvm_done), .HOST_ALIVE_ACK(alive_ack),
      .NVM_STORE_REQ(store_req), .NVM_LOAD_REQ(load_req), .NVM_BUSY(nvm_busy), .NVM_TIMEOUT(nvm_timeout),
      .FAULT_CLEAR(fault_clr), .RETRY_CLEAR(retry_clr), .HOST_ALIVE(host_alive), .KEY_REJECT(key_reject),
      .CMD_REFUSED(cmd_refused));

   acs_ctl_model acs_ctl_model_inst (.SYS_CLK(sys_clk), .SRST(srst), .STORE_REQ(store_req),
      .LOAD_REQ(load_req), .HOST_ALIVE(host_alive), .DELAY(delay), .MUTE(mute), .NVM_DONE(nvm_done),
      .HOST_ALIVE_ACK(alive_ack));

   always #5 sys_clk = ~sys_clk;

   // pulses last one cycle, so one look per cycle counts each exactly once
   always @(negedge sys_clk) begin
      for (int k = 0; k < 7; k++) begin
         if (pulses[k] === 1'b1) cnt[k]++;
      end
   end

   task automatic summarize;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input acs_word_t got, input acs_word_t exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnts(input logic [6:0][3:0] e);
      for (int k = 0; k < 7; k++) chk(32'(cnt[k]), 32'(e[k]));
   endtask

   task automatic zero;
      @(posedge sys_clk);
      cnt = '{default: 0};
      @(negedge sys_clk);
   endtask

   task automatic done(input string s);
      $display("test %s done, %0d mismatches so far", s, n_fail);
   endtask

   // each cycle the strobe stays high is one write
   task automatic wr(input acs_addr_t a, input acs_word_t d, input int n);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      repeat (n) @(negedge sys_clk);
      reg_wr = 1'b0;
      // one idle cycle keeps back-to-back calls from re-raising the strobe in the same step
      @(negedge sys_clk);
   endtask

   task automatic rd(input acs_addr_t a, output acs_word_t d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hffff_ffff;
      @(negedge sys_clk);
   endtask

   task automatic wait_idle(input int lim);
      int i;
      for (i = 0; i < lim && nvm_busy !== 1'b0; i++) @(negedge sys_clk);
      if (nvm_busy !== 1'b0) begin
         n_fail++;
         summarize;
      end
   endtask

   localparam acs_word_t STORE_OK = {1'b1, 3'b000, `ACS_UNLOCK_KEY, 20'h00000};

   initial begin
      acs_word_t d;
      int i;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      zero;
      rd(`ACS_OFF_CMD_WORD, d); chk(d, `ACS_CMD_RESET);
      chk({31'h0, host_alive}, 32'h0);
      chk_cnts(28'h0);
      done("reset");
      cur_in = 16'h0a80;
      pwr_in = 16'h0c80;
      repeat (3) @(negedge sys_clk);
      rd(`ACS_OFF_STATUS, d); chk(d, {16'h0a80, 16'h0c80});
      rd(12'h0e8, d); chk(d, 32'h0);
      done("status");
      wr(`ACS_OFF_CMD_WORD, STORE_OK, 1); chk({31'h0, nvm_busy}, 32'h1);
      wait_idle(50);
      wr(`ACS_OFF_CMD_WORD, {1'b1, 3'b000, ~`ACS_UNLOCK_KEY, 20'h00000}, 1);
      repeat (3) @(negedge sys_clk);
      chk_cnts(28'h1000010);
      done("store");
      zero;
      delay = 12'h028;
      wr(`ACS_OFF_CMD_WORD, 32'h4000_0000, 1);
      repeat (3) @(negedge sys_clk);
      wr(`ACS_OFF_CMD_WORD, 32'h4000_0000, 1);
      wait_idle(100);
      chk_cnts(28'h0100001);
      done("load");
      zero;
      wr(`ACS_OFF_CMD_WORD, STORE_OK | 32'h4000_0000, 1);
      wait_idle(100);
      chk_cnts(28'h1000000);
      done("store and load");
      zero;
      wr(`ACS_OFF_CMD_WORD, 32'h3000_0000, 2);
      wr(12'h0e8, 32'hf5a0_0001, 1);
      ce = 1'b0;
      wr(`ACS_OFF_CMD_WORD, 32'h3000_0000, 1);
      ce = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk_cnts(28'h0022000);
      chk({31'h0, host_alive}, 32'h0);
      done("clears");
      wr(`ACS_OFF_CMD_WORD, 32'h0000_0001, 1);
      chk({31'h0, host_alive}, 32'h1);
      for (i = 0; i < 10 && host_alive !== 1'b0; i++) @(negedge sys_clk);
      chk({31'h0, host_alive}, 32'h0);
      done("alive");
      zero;
      mute = 1'b1;
      wr(`ACS_OFF_CMD_WORD, STORE_OK, 1);
      wait_idle(1100);
      repeat (2) @(negedge sys_clk);
      chk_cnts(28'h1000100);
      mute = 1'b0;
      done("timeout");
      summarize;
   end
endmodule // tb_acs_regs
